// [rtl/rwc_regs.svh]
/*
 * Register map, field thresholds and reset values of the receive word
 * check and status block.
 * Assumes an APB bus with 32-bit data and byte addresses.
 */
//
// Function
// - status register is read-only: queue flags, mode bits, word error flags.
// - status returns to reset at power-up and reset; a queue clear write resets all but the mode bits.
// - bit 8 sets on sequence or control bit error per mode; sticky.
// - bit 7 is 1 when queue full; also drives processor interrupt.
// - bit 6 is 1 above 32 words, 0 at 32 or fewer.
// - half-full bit is 0 above 4096 words, 1 below.
// - mode bits 2..1: 10 frequency, 00 gradient, 01 receiver unit, 11 reserved.
// - every word gets parity checked; failure sets sticky bit 0.
// - receive path takes words at the far end's documented word rates.
// - each word classed empty or valid; valid stored, empty rejected.
// - each word checked for its expected sequence position; violation sets bit 8.
// - erroneous words still get written into the queue.
// - read-only version register: slot 15..12, revision 11..8, sub-revision 7..0.
// - slot field codes slots 1..9; plug-in board default 1011.
// - revision field marks fitted memory: 0000, 0001, 0010.
// - sub-revision field is a fixed engineering code, base all zeros.
// - any write to queue clear address clears count, flags and parity error.
// - status mode bits follow the mode written to the control register.
`ifndef RWC_REGS_SVH
`define RWC_REGS_SVH

// ==========================================================
// addresses
`define RWC_ADDR_FIFO_CLEAR 32'h0600_0004
`define RWC_ADDR_STATUS 32'h0600_0008
`define RWC_ADDR_CONTROL 32'h0600_000C
`define RWC_ADDR_VERSION 32'h6000_0038
`define RWC_ADDR_IRQ_STATUS 32'h0600_0040
`define RWC_ADDR_IRQ_CLEAR 32'h0600_0044
`define RWC_ADDR_IRQ_ENABLE 32'h0600_0048

// ==========================================================
// fields and values
`define RWC_MODE_GRAD 2'h0
`define RWC_MODE_RXU 2'h1
`define RWC_MODE_FREQ 2'h2
`define RWC_MODE_RESET 2'h2
`define RWC_ABOVE_WORDS 32
`define RWC_HALF_WORDS 4096
`define RWC_IRQ_WORD_SEQUENCE_ERROR 0
`define RWC_IRQ_INPUT_PARITY_ERROR 1
`define RWC_IRQ_FULL 2

`endif

// [rtl/rwc_pkg.sv]
/*
 * Types of the receive word check and status block.
 * Assumes nothing beyond the register header.
 */
package rwc_pkg;

   typedef struct packed {
      logic [6:0] unused;
      logic word_sequence_error;
      logic queue_input_ready;
      logic queue_above_threshold;
      logic queue_output_empty;
      logic queue_near_empty_n;
      logic queue_half_full;
      logic [1:0] mode;
      logic input_parity_error;
   } rwc_status_t;

   typedef struct packed {
      logic [3:0] slot;
      logic [3:0] revision;
      logic [7:0] sub_revision;
   } rwc_version_t;

   typedef struct packed {
      logic [47:0] data;
      logic parity;
   } rwc_link_word_t;

endpackage : rwc_pkg

// [rtl/rwc_top.sv]
/*
 * Receive word check and status block: samples the parallel link, classes
 * and checks each word, writes accepted words towards the queue, tracks the
 * queue fill and presents status, version and interrupt registers on APB.
 * Assumes the link clock is far slower than clk and the queue reader pulses
 * queue_read on clk.
 */
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "rwc_regs.svh"

module rwc_top
   import rwc_pkg::*;
#(
   parameter int DEPTH = 8192,
   parameter logic [3:0] SLOT = 4'hB,
   parameter logic [3:0] REVISION = 4'h0,
   parameter logic [7:0] SUB_REVISION = 8'h00
) (
   input wire logic clk, // 10 MHz
   input wire logic rst_n, // async, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [31:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic link_clk, // link clock pin
   input wire rwc_link_word_t link_word, // link word and parity pins
   input wire logic queue_read, // reader took one word
   output logic queue_write, // one-cycle store strobe
   output rwc_link_word_t queue_data, // word to store
   output logic processor_external_interrupt, // queue full
   output logic irq // enabled event pending
);

   localparam int CW = $clog2(DEPTH + 1);

   // ==========================================================
   // apb decode
   logic setup;
   logic wr_en;
   logic mapped;
   logic fifo_clear;
   logic [31:0] rdata_d;
   logic [31:0] prdata_q;
   logic pslverr_q;
   // state read by the decoder is declared ahead of it
   logic [1:0] mode_q;
   logic [2:0] irq_sts_q;
   logic [2:0] irq_en_q;
   rwc_status_t status;
   rwc_version_t version;

   always_comb begin
      mapped = 1'b1;
      rdata_d = 32'h0000_0000;
      case (paddr)
         `RWC_ADDR_FIFO_CLEAR: rdata_d = 32'h0000_0000;
         `RWC_ADDR_STATUS: rdata_d = {16'h0000, status};
         `RWC_ADDR_CONTROL: rdata_d = {30'h0000_0000, mode_q};
         `RWC_ADDR_VERSION: rdata_d = {16'h0000, version};
         `RWC_ADDR_IRQ_STATUS: rdata_d = {29'h0000_0000, irq_sts_q};
         `RWC_ADDR_IRQ_CLEAR: rdata_d = 32'h0000_0000;
         `RWC_ADDR_IRQ_ENABLE: rdata_d = {29'h0000_0000, irq_en_q};
         default: mapped = 1'b0;
      endcase
   end

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & mapped;
   assign fifo_clear = wr_en & (paddr == `RWC_ADDR_FIFO_CLEAR);
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // read data settles in the setup cycle, so zero-wait access is safe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
         pslverr_q <= ~mapped;
      end
   end

   // ==========================================================
   // control register

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= `RWC_MODE_RESET;
      end else if (wr_en && paddr == `RWC_ADDR_CONTROL) begin
         mode_q <= pwdata[1:0];
      end
   end

   // ==========================================================
   // link sampling
   // the link clock is slow, so its edges are found on clk; data is
   // stable around the rising edge, hence a plain two-stage bus sync
   logic [2:0] lclk_q;
   rwc_link_word_t lw_s1_q;
   rwc_link_word_t lw_s2_q;
   logic word_stb;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lclk_q <= 3'h0;
      end else begin
         lclk_q <= {lclk_q[1:0], link_clk};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lw_s1_q <= '0;
         lw_s2_q <= '0;
      end else begin
         lw_s1_q <= link_word;
         lw_s2_q <= lw_s1_q;
      end
   end

   // one word per rising link clock edge, for link clocks far slower than clk
   assign word_stb = lclk_q[1] & ~lclk_q[2];

   // ==========================================================
   // word classification
   logic [1:0] ident;
   logic accept;
   logic seq_err;
   logic par_bad;
   logic prev_a_q;

   assign ident = lw_s2_q.data[47:46];
   assign par_bad = ~(^lw_s2_q); // odd parity over word and parity bit

   always_comb begin
      accept = 1'b0;
      seq_err = 1'b0;
      case (mode_q)
         `RWC_MODE_FREQ: begin
            // bit 47 low is an opening word, high a follower
            if (!ident[1]) begin
               accept = 1'b1;
               seq_err = prev_a_q;
            end else begin
               accept = prev_a_q;
            end
         end
         `RWC_MODE_GRAD, `RWC_MODE_RXU: begin
            accept = (ident != 2'h3);
            seq_err = (ident == 2'h0);
         end
         default: begin
            accept = 1'b0;
            seq_err = 1'b0;
         end
      endcase
   end

   // follower is only legal right after an opening word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_a_q <= 1'b0;
      end else if (fifo_clear) begin
         prev_a_q <= 1'b0;
      end else if (word_stb) begin
         prev_a_q <= (mode_q == `RWC_MODE_FREQ) & ~ident[1];
      end
   end

   // ==========================================================
   // sticky error flags
   logic word_sequence_error_q;
   logic input_parity_error_q;

   // a new error in the clear cycle wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_sequence_error_q <= 1'b0;
      end else if (word_stb && seq_err) begin
         word_sequence_error_q <= 1'b1;
      end else if (fifo_clear) begin
         word_sequence_error_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         input_parity_error_q <= 1'b0;
      end else if (word_stb && par_bad) begin
         input_parity_error_q <= 1'b1;
      end else if (fifo_clear) begin
         input_parity_error_q <= 1'b0;
      end
   end

   // ==========================================================
   // store path and fill count
   logic [CW-1:0] count_q;
   logic full;
   logic wr_go;
   logic rd_go;
   logic queue_write_q;
   rwc_link_word_t queue_data_q;

   assign full = (count_q == CW'(DEPTH));
   // words that arrive while full are lost; the full flag tells software
   assign wr_go = word_stb & accept & ~full;
   assign rd_go = queue_read & (count_q != '0);
   assign queue_write = queue_write_q;
   assign queue_data = queue_data_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         queue_write_q <= 1'b0;
         queue_data_q <= '0;
      end else begin
         queue_write_q <= wr_go & ~fifo_clear;
         if (wr_go) begin
            queue_data_q <= lw_s2_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (fifo_clear) begin
         count_q <= '0;
      end else if (wr_go && !rd_go) begin
         count_q <= count_q + CW'(1);
      end else if (rd_go && !wr_go) begin
         count_q <= count_q - CW'(1);
      end
   end

   // ==========================================================
   // status and version
   // fill is widened so the fixed 32 and 4096 word thresholds still compare
   // correctly when DEPTH is too small to hold them in count_q
   logic [31:0] fill;

   assign fill = 32'(count_q);

   always_comb begin
      status = '0;
      status.word_sequence_error = word_sequence_error_q;
      status.queue_input_ready = full;
      status.queue_above_threshold = (fill > 32'(`RWC_ABOVE_WORDS));
      status.queue_output_empty = (count_q == '0);
      status.queue_near_empty_n = (fill > 32'(`RWC_ABOVE_WORDS));
      status.queue_half_full = (fill < 32'(`RWC_HALF_WORDS));
      status.mode = mode_q;
      status.input_parity_error = input_parity_error_q;
   end

   always_comb begin
      version.slot = SLOT;
      version.revision = REVISION;
      version.sub_revision = SUB_REVISION;
   end

   assign processor_external_interrupt = full;

   // ==========================================================
   // interrupts
   logic [2:0] irq_evt;
   logic [2:0] irq_clr;

   always_comb begin
      irq_evt = 3'h0;
      irq_evt[`RWC_IRQ_WORD_SEQUENCE_ERROR] = word_stb & seq_err;
      irq_evt[`RWC_IRQ_INPUT_PARITY_ERROR] = word_stb & par_bad;
      irq_evt[`RWC_IRQ_FULL] = wr_go & (count_q == CW'(DEPTH - 1)) & ~rd_go;
   end

   assign irq_clr = (wr_en && paddr == `RWC_ADDR_IRQ_CLEAR) ? pwdata[2:0] : 3'h0;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_irq
         // set wins over a clear in the same cycle
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               irq_sts_q[gi] <= 1'b0;
            end else if (irq_evt[gi]) begin
               irq_sts_q[gi] <= 1'b1;
            end else if (irq_clr[gi]) begin
               irq_sts_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_q <= 3'h0;
      end else if (wr_en && paddr == `RWC_ADDR_IRQ_ENABLE) begin
         irq_en_q <= pwdata[2:0];
      end
   end

   assign irq = |(irq_sts_q & irq_en_q);

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_ver_setup;
      psel && !penable && !pwrite && paddr == `RWC_ADDR_VERSION;
   endsequence

   sequence s_ver_access;
      psel && penable && pready;
   endsequence

   AST_VERSION_READ: assert property (
      s_ver_setup ##1 s_ver_access |-> prdata[15:0] == {SLOT, REVISION, SUB_REVISION}
         && prdata[31:16] == 16'h0000)
      else $error("version read returned wrong value");

   AST_STATUS_READ: assert property (
      psel && !penable && !pwrite && paddr == `RWC_ADDR_STATUS
         |=> prdata[8] == $past(word_sequence_error_q) && prdata[0] == $past(input_parity_error_q)
         && prdata[2:1] == $past(mode_q))
      else $error("status read does not show error flags or mode");

   AST_WORD_SEQUENCE_ERROR_STICKY: assert property (
      word_sequence_error_q && !fifo_clear |=> word_sequence_error_q)
      else $error("word error flag dropped without clear");

   AST_INPUT_PARITY_ERROR_SET: assert property (
      word_stb && par_bad |=> input_parity_error_q && status.input_parity_error)
      else $error("parity failure not flagged");

   AST_CLEAR: assert property (
      fifo_clear && !(word_stb && (seq_err || par_bad))
         |=> !word_sequence_error_q && !input_parity_error_q && count_q == '0 && status.queue_half_full)
      else $error("queue clear did not reset status");

   AST_FULL_INT: assert property (
      processor_external_interrupt == (count_q == CW'(DEPTH))
         && status.queue_input_ready == processor_external_interrupt)
      else $error("full flag and interrupt disagree");

   AST_ABOVE_RISE: assert property (
      $rose(status.queue_above_threshold) |-> $past(fill) == 32'(`RWC_ABOVE_WORDS))
      else $error("threshold flag rose at wrong fill");

   AST_HALF_FALL: assert property (
      $fell(status.queue_half_full) |-> $past(fill) == 32'(`RWC_HALF_WORDS - 1))
      else $error("half-full flag fell at wrong fill");

   AST_MODE_WRITE: assert property (
      wr_en && paddr == `RWC_ADDR_CONTROL |=> status.mode == $past(pwdata[1:0]))
      else $error("mode bits do not follow control write");

   AST_STORE_ON_ERR: assert property (
      word_stb && accept && (par_bad || seq_err) && !full && !fifo_clear
         |=> queue_write && queue_data == $past(lw_s2_q))
      else $error("erroneous word not stored");

   AST_EMPTY_REJECT: assert property (
      word_stb && mode_q != `RWC_MODE_FREQ && ident == 2'h3 |=> !queue_write)
      else $error("empty word stored");

   AST_A_AFTER_A: assert property (
      word_stb && mode_q == `RWC_MODE_FREQ && !ident[1] && prev_a_q |=> word_sequence_error_q[*2])
      else $error("repeated opening word not flagged");

endmodule : rwc_top
`default_nettype wire

// [test/rwc_link_model.sv]
/*
 * Behavioural model of the sequencer that drives the parallel link.
 * Assumes the receiver samples link_clk on its own clock and takes the word on the rising edge.
 */
`timescale 1ns/10ps
`default_nettype none

module rwc_link_model
   import rwc_pkg::*;
(
   output logic link_clk, // stands low between words
   output rwc_link_word_t link_word // word and parity lines
);
   initial begin
      link_clk = 1'b0;
      link_word = '0;
   end

   // one word per 833 ns call; bad flips the odd parity bit on purpose
   task automatic send_word(input logic [47:0] d, input logic bad);
      #33;
      link_word.data = d;
      link_word.parity = (~^d) ^ bad;
      #400 link_clk = 1'b1;
      #400 link_clk = 1'b0;
      // released lines must not keep the old word, or a late sample would pass unseen
      link_word = ~link_word;
   endtask : send_word
endmodule : rwc_link_model

`default_nettype wire

// [test/tb.sv]
/*
 * Self-checking bench of the receive word check block: APB register tests and link traffic.
 * Assumes the register header, the package and the link model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rwc_regs.svh"

module tb;
   import rwc_pkg::*;
   localparam int DEPTH_T = 64;
   localparam logic [3:0] SLOT_T = 4'h9;
   localparam logic [3:0] REV_T = 4'h2;
   localparam logic [7:0] SUB_T = 8'h00;
   logic clk = 1'b0;
   logic rst_n, psel, penable, pwrite, pready, pslverr, link_clk, queue_read, queue_write;
   logic processor_external_interrupt, irq, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   rwc_link_word_t link_word, queue_data, last_word;
   int mismatches = 0;
   int total_checks = 0;
   int wr_count = 0;

   always #50 clk = ~clk;
   always @(posedge clk) if (queue_write === 1'b1) begin
      wr_count++;
      last_word = queue_data;
   end

   rwc_top #(.DEPTH(DEPTH_T), .SLOT(SLOT_T), .REVISION(REV_T), .SUB_REVISION(SUB_T)) rwc_top_inst (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
      .link_word(link_word), .queue_read(queue_read), .queue_write(queue_write),
      .queue_data(queue_data), .processor_external_interrupt(processor_external_interrupt), .irq(irq));
   rwc_link_model rwc_link_model_inst (.link_clk(link_clk), .link_word(link_word));

   // ==========================================================
   // compare, bus and link tasks
   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_reg

   task automatic check_word(input logic [48:0] got, input logic [48:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_word

   // waits as long as the slave needs; only the watchdog ends a hang
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never re-drives psel in this time step
      @(posedge clk);
   endtask : apb

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      check_reg(rd, exp, what);
   endtask : rd_chk

   task automatic send(input logic [47:0] d, input logic bad);
      rwc_link_model_inst.send_word(d, bad);
      repeat (4) @(posedge clk);
   endtask : send

   function automatic logic [31:0] stat_exp(input int fill, input logic [1:0] m, input logic we, input logic pe);
      rwc_status_t s;
      s = '0;
      s.word_sequence_error = we;
      s.queue_input_ready = (fill == DEPTH_T);
      s.queue_above_threshold = (fill > 32);
      s.queue_output_empty = (fill == 0);
      s.queue_near_empty_n = (fill > 32);
      s.queue_half_full = (fill < 4096);
      s.mode = m;
      s.input_parity_error = pe;
      return {16'h0000, s};
   endfunction : stat_exp

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   // ==========================================================
   // tests
   initial begin
      #1_000_000;
      mismatches++;
      close_out();
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      queue_read = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(0, `RWC_MODE_RESET, 0, 0), "status reset");
      apb(1'b1, `RWC_ADDR_STATUS, 32'hFFFF_FFFF);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(0, `RWC_MODE_RESET, 0, 0), "status read only");
      rd_chk(`RWC_ADDR_VERSION, {16'h0000, SLOT_T, REV_T, SUB_T}, "version");
      check_reg({31'h0000_0000, er}, 32'h0000_0000, "mapped no error");
      apb(1'b1, `RWC_ADDR_VERSION, 32'h0000_0000);
      rd_chk(`RWC_ADDR_VERSION, {16'h0000, SLOT_T, REV_T, SUB_T}, "version read only");
      apb(1'b0, 32'h0600_0010, 32'h0000_0000);
      check_reg({31'h0000_0000, er}, 32'h0000_0001, "unmapped error");
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `RWC_ADDR_CONTROL, 32'(m));
         rd_chk(`RWC_ADDR_STATUS, stat_exp(0, 2'(m), 0, 0), "mode field");
      end
      $display("test registers done");

      apb(1'b1, `RWC_ADDR_CONTROL, {30'h0000_0000, `RWC_MODE_RXU});
      apb(1'b1, `RWC_ADDR_IRQ_ENABLE, 32'h0000_0007);
      send(48'h4000_0000_1234, 1'b0);
      check_word(last_word, {48'h4000_0000_1234, ~^48'h4000_0000_1234}, "stored word");
      send(48'hC000_0000_0055, 1'b0);
      check_reg(32'(wr_count), 32'h0000_0001, "empty word refused");
      send(48'h8000_0000_0001, 1'b1);
      check_reg(32'(wr_count), 32'h0000_0002, "parity word stored");
      check_reg({31'h0000_0000, irq}, 32'h0000_0001, "irq on parity event");
      send(48'h0000_0000_0002, 1'b0);
      send(48'h4000_0000_0003, 1'b0);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(4, `RWC_MODE_RXU, 1, 1), "sticky errors");
      rd_chk(`RWC_ADDR_IRQ_STATUS, 32'h0000_0003, "irq status");
      apb(1'b1, `RWC_ADDR_IRQ_CLEAR, 32'h0000_0003);
      rd_chk(`RWC_ADDR_IRQ_STATUS, 32'h0000_0000, "irq cleared");
      check_reg({31'h0000_0000, irq}, 32'h0000_0000, "irq low");
      apb(1'b1, `RWC_ADDR_FIFO_CLEAR, 32'h1234_5678);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(0, `RWC_MODE_RXU, 0, 0), "queue clear");
      apb(1'b1, `RWC_ADDR_CONTROL, {30'h0000_0000, `RWC_MODE_GRAD});
      send(48'h8000_0000_0031, 1'b0);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(1, `RWC_MODE_GRAD, 0, 0), "gradient word");
      apb(1'b1, `RWC_ADDR_FIFO_CLEAR, 32'h0000_0000);
      $display("test receiver mode done");

      apb(1'b1, `RWC_ADDR_CONTROL, {30'h0000_0000, `RWC_MODE_FREQ});
      send(48'h0000_0000_0011, 1'b0);
      send(48'h8000_0000_0012, 1'b0);
      apb(1'b1, `RWC_ADDR_FIFO_CLEAR, 32'h0000_0000);
      wr_count = 0;
      send(48'h0000_0000_0021, 1'b0);
      send(48'h8000_0000_0022, 1'b0);
      send(48'h8000_0000_0023, 1'b0);
      send(48'h0000_0000_0024, 1'b0);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(3, `RWC_MODE_FREQ, 0, 0), "pair sequence");
      send(48'h0000_0000_0025, 1'b0);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(4, `RWC_MODE_FREQ, 1, 0), "opener twice");
      check_reg(32'(wr_count), 32'h0000_0004, "pair count");
      $display("test pair mode done");

      apb(1'b1, `RWC_ADDR_CONTROL, {30'h0000_0000, `RWC_MODE_RXU});
      // the repeated opener above left a word error event pending
      apb(1'b1, `RWC_ADDR_IRQ_CLEAR, 32'h0000_0007);
      apb(1'b1, `RWC_ADDR_FIFO_CLEAR, 32'h0000_0000);
      wr_count = 0;
      for (int i = 0; i < 32; i++) send(48'h4000_0000_0100 + 48'(i), 1'b0);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(32, `RWC_MODE_RXU, 0, 0), "fill 32");
      send(48'h4000_0000_0200, 1'b0);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(33, `RWC_MODE_RXU, 0, 0), "fill 33");
      for (int i = 33; i < DEPTH_T; i++) send(48'h4000_0000_0300 + 48'(i), 1'b0);
      rd_chk(`RWC_ADDR_STATUS, stat_exp(DEPTH_T, `RWC_MODE_RXU, 0, 0), "full");
      check_reg({31'h0000_0000, processor_external_interrupt}, 32'h0000_0001, "full interrupt");
      rd_chk(`RWC_ADDR_IRQ_STATUS, 32'h0000_0004, "irq full event");
      send(48'h4000_0000_0400, 1'b0);
      check_reg(32'(wr_count), 32'(DEPTH_T), "write when full dropped");
      queue_read <= 1'b1;
      @(posedge clk);
      queue_read <= 1'b0;
      rd_chk(`RWC_ADDR_STATUS, stat_exp(DEPTH_T - 1, `RWC_MODE_RXU, 0, 0), "after read");
      check_reg({31'h0000_0000, processor_external_interrupt}, 32'h0000_0000, "interrupt off");
      $display("test fill done");
      close_out();
   end
endmodule : tb

`default_nettype wire
